// *** src/pmoe_control.sv ***
/*
 * pmoe_control: output on/off control of a power module. Holds the page,
 * run and enable source configuration registers reached by command code,
 * combines the run command with the enable pin, drives the power stage
 * enable and keeps the sticky fault status.
 * assumes: a bus transport delivers one decoded command per cmd_valid
 * pulse; enable_pin and fault_event are synchronous to clock.
 */
`default_nettype none
// Notes on behaviour
// R1: page accepts only 0x00 and 0xff and changes nothing else.
// R2: run field 00 turns the output off at once, no sequencing.
// R3: run field 10 turns the output on to the set voltage.
// R4: run field acts only while bus enable mode is set.
// R5: bus enable mode rising clears run command and turns output off.
// R6: host should turn the output off before changing bus enable mode.
// R7: with pin and bus modes both set, run needs the pin active.
// R8: with pin mode set the enable pin controls the output, whatever run holds; with bus mode also set, an active pin still needs run at on.
// R9: power-up bit stays one; output waits for pin and run together; the code waits only for sources whose mode bit is set.
// R10: bus enable mode clear makes the run field ignored.
// R11: bus enable mode set needs run field at on to start.
// R12: pin mode clear makes the enable pin ignored.
// R13: pin mode set needs the enable pin asserted to start.
// R14: polarity bit one means high enables, zero means low enables.
// R15: off-action bit stays one; disable stops energy transfer at once.
// R16: clear command empties every fault status bit; a bit whose fault event comes in the clearing cycle stays set.
// R17: run bits 5:0 are ignored; other field codes change nothing.
module pmoe_control #(
    parameter int FAULT_W = 8
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_code,
    input wire logic [7:0] cmd_wdata,
    output logic cmd_ack,
    output logic cmd_nack,
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    input wire logic enable_pin,
    input wire logic [FAULT_W-1:0] fault_event,
    output logic [FAULT_W-1:0] fault_status,
    output logic output_on,
    output logic energy_stop
);
    // elaboration check on the fault width
    if (FAULT_W < 1 || FAULT_W > 32) begin : g_fault_check
        $error("pmoe_control: FAULT_W must be 1 to 32");
    end

    logic [7:0] page_reg;
    logic [7:0] run_reg;
    logic [7:0] cfg_reg;
    logic bus_run_reg;
    pmoe_pkg::pmoe_out_t out_reg;
    pmoe_pkg::pmoe_out_t out_next;
    logic rsp_valid_reg;
    logic [7:0] rsp_data_reg;
    logic hit_page;
    logic hit_run;
    logic hit_cfg;
    logic hit_clear;
    logic page_ok;
    logic wr_page;
    logic wr_run;
    logic wr_cfg;
    logic rd_ok;
    logic clear_pulse;
    logic [7:0] cfg_wval;
    logic bus_mode_rise;
    logic [1:0] run_field;
    logic pin_active;
    logic pin_allows;
    logic bus_allows;

    // command decode
    assign hit_page = cmd_code == pmoe_pkg::CMD_PAGE;
    assign hit_run = cmd_code == pmoe_pkg::CMD_RUN;
    assign hit_cfg = cmd_code == pmoe_pkg::CMD_CFG;
    assign hit_clear = cmd_code == pmoe_pkg::CMD_CLEAR;
    assign page_ok = (cmd_wdata == pmoe_pkg::PAGE_LOW) || (cmd_wdata == pmoe_pkg::PAGE_ALL);

    // accepted writes, reads and the send-byte clear
    assign wr_page = cmd_valid && cmd_write && hit_page && page_ok; // R1
    assign wr_run = cmd_valid && cmd_write && hit_run;
    assign wr_cfg = cmd_valid && cmd_write && hit_cfg;
    assign clear_pulse = cmd_valid && cmd_write && hit_clear;
    assign rd_ok = cmd_valid && !cmd_write && (hit_page || hit_run || hit_cfg);

    // handshake answers in the command cycle
    assign cmd_ack = wr_page || wr_run || wr_cfg || clear_pulse || rd_ok;
    assign cmd_nack = cmd_valid && !cmd_ack;

    // fixed bits are forced to one whatever the host writes
    always_comb begin
        cfg_wval = cmd_wdata;
        cfg_wval[pmoe_pkg::CFG_POWERUP] = 1'b1; // R9
        cfg_wval[pmoe_pkg::CFG_OFF_ACT] = 1'b1; // R15
    end

    // entering bus enable mode
    assign bus_mode_rise = wr_cfg && cfg_wval[pmoe_pkg::CFG_BUS_EN]
        && !cfg_reg[pmoe_pkg::CFG_BUS_EN];
    assign run_field = cmd_wdata[pmoe_pkg::RUN_FIELD_HI:pmoe_pkg::RUN_FIELD_LO];

    // page register, no effect on anything else
    always_ff @(posedge clock) begin
        if (rst) begin
            page_reg <= pmoe_pkg::PAGE_RESET;
        end else if (wr_page) begin
            page_reg <= cmd_wdata; // R1
        end
    end

    // run command register, forced to zero on bus mode entry
    always_ff @(posedge clock) begin
        if (rst) begin
            run_reg <= pmoe_pkg::RUN_RESET;
        end else if (bus_mode_rise) begin
            run_reg <= 8'h00; // R5
        end else if (wr_run) begin
            run_reg <= cmd_wdata;
        end
    end

    // remembered on/off request, changed by the two known codes and cleared on bus mode entry
    always_ff @(posedge clock) begin
        if (rst) begin
            bus_run_reg <= 1'b0;
        end else if (bus_mode_rise) begin
            bus_run_reg <= 1'b0; // R5
        end else if (wr_run && run_field == pmoe_pkg::RUN_OFF) begin
            bus_run_reg <= 1'b0; // R2
        end else if (wr_run && run_field == pmoe_pkg::RUN_ON) begin
            bus_run_reg <= 1'b1; // R3
        end
    end

    // enable source configuration register
    always_ff @(posedge clock) begin
        if (rst) begin
            cfg_reg <= pmoe_pkg::CFG_RESET;
        end else if (wr_cfg) begin
            cfg_reg <= cfg_wval;
        end
    end

    // enable pin level qualified by polarity and pin mode
    assign pin_active = enable_pin == cfg_reg[pmoe_pkg::CFG_PIN_POL]; // R14
    assign pin_allows = !cfg_reg[pmoe_pkg::CFG_PIN_EN] || pin_active; // R12 R13

    // run request counts only in bus enable mode
    assign bus_allows = !cfg_reg[pmoe_pkg::CFG_BUS_EN] || bus_run_reg; // R4 R10 R11

    // output needs every enabled source; the pin gates regardless of run
    always_comb begin
        out_next = pmoe_pkg::PMOE_OUT_OFF;
        if (pin_allows && bus_allows && !bus_mode_rise) begin // R7 R8 R9
            out_next = pmoe_pkg::PMOE_OUT_ON;
        end
    end

    // power stage enable state
    always_ff @(posedge clock) begin
        if (rst) begin
            out_reg <= pmoe_pkg::PMOE_OUT_OFF;
        end else begin
            unique case (out_next)
                pmoe_pkg::PMOE_OUT_ON: out_reg <= pmoe_pkg::PMOE_OUT_ON;
                pmoe_pkg::PMOE_OUT_OFF: out_reg <= pmoe_pkg::PMOE_OUT_OFF; // R15
            endcase
        end
    end

    assign output_on = out_reg == pmoe_pkg::PMOE_OUT_ON;
    // immediate off: stop transferring energy whenever not on
    assign energy_stop = out_reg == pmoe_pkg::PMOE_OUT_OFF; // R15

    // read data one cycle after an accepted read
    always_ff @(posedge clock) begin
        if (rst) begin
            rsp_valid_reg <= 1'b0;
            rsp_data_reg <= 8'h00;
        end else begin
            rsp_valid_reg <= rd_ok;
            if (rd_ok) begin
                if (hit_page) begin
                    rsp_data_reg <= page_reg;
                end else if (hit_run) begin
                    rsp_data_reg <= run_reg;
                end else begin
                    rsp_data_reg <= cfg_reg;
                end
            end
        end
    end

    assign rsp_valid = rsp_valid_reg;
    assign rsp_data = rsp_data_reg;

    // sticky fault status
    pmoe_fault_latch #(
        .WIDTH(FAULT_W)
    ) u_faults (
        .clock(clock),
        .rst(rst),
        .event_in(fault_event),
        .clear(clear_pulse), // R16
        .status(fault_status)
    );

    // checks on the enable logic
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    // page only ever holds a valid value
    page_legal_a: assert property ( // R1
        page_reg == pmoe_pkg::PAGE_LOW || page_reg == pmoe_pkg::PAGE_ALL)
        else $error("page holds an invalid value");

    // bad page values are refused and leave the register alone
    page_refuse_a: assert property ( // R1
        (cmd_valid && cmd_write && hit_page && !page_ok)
        |-> cmd_nack ##1 $stable(page_reg))
        else $error("invalid page value accepted");

    // run off in bus mode turns the output off two edges later
    run_off_a: assert property ( // R2
        (wr_run && run_field == pmoe_pkg::RUN_OFF && cfg_reg[pmoe_pkg::CFG_BUS_EN])
        |-> ##2 !output_on)
        else $error("run off did not turn output off");

    // run on with everything allowing turns the output on
    run_on_a: assert property ( // R3
        (wr_run && run_field == pmoe_pkg::RUN_ON && !cfg_reg[pmoe_pkg::CFG_PIN_EN])
        ##1 !wr_cfg |=> output_on)
        else $error("run on did not turn output on");

    // outside bus mode the run field has no say
    bus_ignore_a: assert property ( // R4
        (!cfg_reg[pmoe_pkg::CFG_BUS_EN] && pin_allows && !bus_mode_rise)
        |=> output_on)
        else $error("output off although run field is ignored");

    // entering bus mode clears run and switches off
    mode_entry_a: assert property ( // R5
        bus_mode_rise |=> (run_reg == 8'h00 && !bus_run_reg && !output_on))
        else $error("bus mode entry did not clear run");

    // both modes set: inactive pin blocks a run request
    pin_and_bus_a: assert property ( // R7
        (cfg_reg[pmoe_pkg::CFG_PIN_EN] && cfg_reg[pmoe_pkg::CFG_BUS_EN]
        && bus_run_reg && !pin_active) |=> !output_on)
        else $error("run honoured with inactive pin");

    // pin alone turns the output off whatever run holds
    pin_override_a: assert property ( // R8
        (cfg_reg[pmoe_pkg::CFG_PIN_EN] && !pin_active) |=> !output_on)
        else $error("pin could not turn output off");

    // fixed bits always read as one
    fixed_bits_a: assert property ( // R9
        cfg_reg[pmoe_pkg::CFG_POWERUP] && cfg_reg[pmoe_pkg::CFG_OFF_ACT])
        else $error("fixed configuration bit cleared");

    // in bus mode, no start without a run request
    bus_start_a: assert property ( // R11
        (cfg_reg[pmoe_pkg::CFG_BUS_EN] && !bus_run_reg) |=> !output_on)
        else $error("started without run request");

    // pin ignored when pin mode clear
    pin_ignore_a: assert property ( // R12
        (!cfg_reg[pmoe_pkg::CFG_PIN_EN] && bus_allows && !bus_mode_rise) |=> output_on)
        else $error("pin state used while pin mode clear");

    // polarity selects the enabling level
    polarity_a: assert property ( // R14
        (cfg_reg[pmoe_pkg::CFG_PIN_EN] && !cfg_reg[pmoe_pkg::CFG_BUS_EN]
        && enable_pin == cfg_reg[pmoe_pkg::CFG_PIN_POL] && !wr_cfg) |=> output_on)
        else $error("pin polarity not honoured");

    // energy stops at the next edge once any source blocks
    energy_stop_a: assert property ( // R15
        (!pin_allows || !bus_allows || bus_mode_rise) |=> energy_stop)
        else $error("energy transfer continued after off");

    // clear without new events empties the status
    fault_clear_a: assert property ( // R16
        (clear_pulse && fault_event == '0) |=> fault_status == '0)
        else $error("fault status not cleared");

    // unknown field codes leave the run request unchanged
    dont_care_a: assert property ( // R17
        (wr_run && !bus_mode_rise && run_field != pmoe_pkg::RUN_ON
        && run_field != pmoe_pkg::RUN_OFF) |=> $stable(bus_run_reg))
        else $error("unknown run code changed state");

    // outside bus mode a run write never switches off
    run_ignore_a: assert property ( // R10
        (wr_run && !cfg_reg[pmoe_pkg::CFG_BUS_EN] && pin_allows) |=> output_on)
        else $error("run write acted outside bus mode");

    // a start needs the pin to allow it one edge before
    pin_start_a: assert property ( // R13
        $rose(output_on) |-> $past(pin_allows))
        else $error("started without the enable pin");

    // in bus mode, a start needs the run request one edge before
    run_start_a: assert property ( // R11
        $rose(output_on) |-> $past(bus_allows && !bus_mode_rise))
        else $error("start not requested by run");

    // run register keeps the whole written byte
    run_store_a: assert property ( // R17
        wr_run |=> run_reg == $past(cmd_wdata))
        else $error("run byte not stored");

    // page reads return the stored page value
    page_read_a: assert property ( // R1
        (rd_ok && hit_page) |=> rsp_data == $past(page_reg))
        else $error("page read returned wrong value");

    // config writes outside mode entry leave run alone
    mode_hold_a: assert property ( // R5
        (wr_cfg && !bus_mode_rise) |=> $stable(run_reg))
        else $error("run changed without mode entry");

    // active low pin: a high level blocks the output
    pol_low_a: assert property ( // R14
        (cfg_reg[pmoe_pkg::CFG_PIN_EN] && !cfg_reg[pmoe_pkg::CFG_PIN_POL] && enable_pin)
        |=> !output_on)
        else $error("high pin enabled an active low setup");

    // sticky bits only drop on a clear command
    sticky_hold_a: assert property ( // R16
        !clear_pulse |=> (fault_status & $past(fault_status)) == $past(fault_status))
        else $error("fault bit dropped without clear");

    // run off code always drops the run request
    run_off_req_a: assert property ( // R2
        (wr_run && run_field == pmoe_pkg::RUN_OFF) |=> !bus_run_reg)
        else $error("run off code kept the run request");
endmodule : pmoe_control
`default_nettype wire

// *** pkg/pmoe_pkg.sv ***
/*
 * pmoe_pkg: command codes, field positions and reset values of the
 * output enable control block.
 * assumes: the command-level port is fed by a bus transport that has
 * already decoded the command code and the data byte.
 */
`default_nettype none
package pmoe_pkg;
    // command codes
    localparam logic [7:0] CMD_PAGE = 8'h00;
    localparam logic [7:0] CMD_RUN = 8'h01;
    localparam logic [7:0] CMD_CFG = 8'h02;
    localparam logic [7:0] CMD_CLEAR = 8'h03;

    // page values that are accepted
    localparam logic [7:0] PAGE_LOW = 8'h00;
    localparam logic [7:0] PAGE_ALL = 8'hff;

    // run command on/off field
    localparam int RUN_FIELD_HI = 7;
    localparam int RUN_FIELD_LO = 6;
    localparam logic [1:0] RUN_OFF = 2'b00;
    localparam logic [1:0] RUN_ON = 2'b10;

    // enable source configuration bits
    localparam int CFG_POWERUP = 4;
    localparam int CFG_BUS_EN = 3;
    localparam int CFG_PIN_EN = 2;
    localparam int CFG_PIN_POL = 1;
    localparam int CFG_OFF_ACT = 0;

    // reset values
    localparam logic [7:0] PAGE_RESET = 8'h00;
    localparam logic [7:0] RUN_RESET = 8'h00;
    localparam logic [7:0] CFG_RESET = 8'h17;

    // state of the power stage enable
    typedef enum logic {
        PMOE_OUT_OFF = 1'b0,
        PMOE_OUT_ON = 1'b1
    } pmoe_out_t;
endpackage : pmoe_pkg
`default_nettype wire

// *** src/pmoe_fault_latch.sv ***
/*
 * pmoe_fault_latch: sticky fault status bits, one per fault source.
 * assumes: fault events are one-cycle or level signals synchronous to
 * clock; clear is a one-cycle pulse from the command decoder.
 */
`default_nettype none
module pmoe_fault_latch #(
    parameter int WIDTH = 8
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [WIDTH-1:0] event_in,
    input wire logic clear,
    output logic [WIDTH-1:0] status
);
    // elaboration check on width
    if (WIDTH < 1 || WIDTH > 32) begin : g_width_check
        $error("pmoe_fault_latch: WIDTH must be 1 to 32");
    end

    // one sticky bit per source, a new event beats the clear
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge clock) begin
            if (rst) begin
                status[i] <= 1'b0;
            end else if (event_in[i]) begin
                status[i] <= 1'b1;
            end else if (clear) begin
                status[i] <= 1'b0; // R16
            end
        end
    end

    // event in the clearing cycle survives
    set_wins_a: assert property (@(posedge clock) disable iff (rst)
        (clear && event_in != '0) |=> ((status & $past(event_in)) == $past(event_in)))
        else $error("fault event lost during clear");
endmodule : pmoe_fault_latch
`default_nettype wire

// *** testbench/pmoe_host.sv ***
/*
 * pmoe_host: host model for the command port plus the enable pin driver.
 * assumes: same clock as the block; tasks are called at rising edges.
 */
`default_nettype none
module pmoe_host (
    input wire logic clock,
    input wire logic cmd_ack,
    input wire logic cmd_nack,
    output logic cmd_valid,
    output logic cmd_write,
    output logic [7:0] cmd_code,
    output logic [7:0] cmd_wdata,
    output logic enable_pin
);
    timeunit 1ns;
    timeprecision 1ns;

    // idle bus at time zero
    initial begin
        {cmd_valid, cmd_write, cmd_code, cmd_wdata, enable_pin} = '0;
    end

    // one command, held until the edge that samples the answer
    task automatic send(input logic w, input logic [7:0] code, input logic [7:0] data,
                        output logic ack, output logic nack);
        cmd_valid <= 1'b1;
        cmd_write <= w;
        cmd_code <= code;
        cmd_wdata <= data;
        @(posedge clock);
        ack = cmd_ack;
        nack = cmd_nack;
        cmd_valid <= 1'b0;
        cmd_code <= ~code; // released lines do not keep old value
        cmd_wdata <= ~data;
        @(posedge clock);
    endtask

    // enable pin level
    task automatic pin(input logic v);
        enable_pin <= v;
    endtask
endmodule // pmoe_host
`default_nettype wire

// *** testbench/tb_pmbus_output_enable_control.sv ***
/*
 * tb_pmbus_output_enable_control: self-checking bench of pmoe_control.
 * assumes: pmoe_host drives the command port and the enable pin.
 */
`default_nettype none
module tb_pmbus_output_enable_control;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] c_pg = pmoe_pkg::CMD_PAGE;
    localparam logic [7:0] c_run = pmoe_pkg::CMD_RUN;
    localparam logic [7:0] c_cfg = pmoe_pkg::CMD_CFG;
    logic clock, rst, cmd_valid, cmd_write, cmd_ack, cmd_nack, rsp_valid, enable_pin;
    logic output_on, energy_stop;
    logic [7:0] cmd_code, cmd_wdata, rsp_data, fault_event, fault_status, r;
    int fails = 0;
    int checks = 0;
    logic [7:0] exp_q[$];

    pmoe_host pmoe_host_i (.clock, .cmd_ack, .cmd_nack, .cmd_valid, .cmd_write,
        .cmd_code, .cmd_wdata, .enable_pin);
    pmoe_control pmoe_control_i (.clock, .rst, .cmd_valid, .cmd_write, .cmd_code,
        .cmd_wdata, .cmd_ack, .cmd_nack, .rsp_valid, .rsp_data, .enable_pin,
        .fault_event, .fault_status, .output_on, .energy_stop);

    // 10 mhz clock
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] want);
        checks++;
        if (seen !== want) begin
            fails++;
            $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    task automatic close_out();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // command with expected acceptance
    task automatic cmd(input logic w, input logic [7:0] code, input logic [7:0] d,
                       input logic acc);
        logic a, n;
        pmoe_host_i.send(w, code, d, a, n);
        chk({7'h00, a}, {7'h00, acc});
        chk({7'h00, n}, {7'h00, ~acc});
    endtask

    // read: note the expected byte, then ask
    task automatic rd(input logic [7:0] code, input logic [7:0] want);
        exp_q.push_back(want);
        cmd(1'b0, code, 8'h00, 1'b1);
    endtask

    // output level once the two-edge latency has passed
    task automatic out(input logic want);
        repeat (2) @(posedge clock);
        @(negedge clock);
        chk({7'h00, output_on}, {7'h00, want});
        chk({7'h00, energy_stop}, {7'h00, ~want});
        @(posedge clock);
    endtask

    // response watcher: oldest note against each read answer
    always @(negedge clock) begin
        if (rsp_valid === 1'b1) begin
            if (exp_q.size() == 0)
                chk(rsp_data, ~rsp_data);
            else
                chk(rsp_data, exp_q.pop_front());
        end
    end

    // watchdog
    initial begin
        #200000;
        fails++;
        close_out();
    end

    // main sequence
    initial begin
        rst = 1'b1;
        fault_event = 8'h00;
        r = 8'($urandom(71));
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        pmoe_host_i.pin(1'b1);
        rd(c_pg, 8'h00);
        rd(c_run, 8'h00);
        rd(c_cfg, 8'h17);
        out(1'b1);
        pmoe_host_i.pin(1'b0);
        out(1'b0);
        $display("test reset done");
        // active low pin
        cmd(1'b1, c_cfg, 8'h15, 1'b1);
        out(1'b1);
        pmoe_host_i.pin(1'b1);
        out(1'b0);
        $display("test polarity done");
        // page: two values taken, the rest refused, no effect on output
        cmd(1'b1, c_pg, 8'hff, 1'b1);
        r = 8'h01 + 8'($urandom % 254);
        cmd(1'b1, c_pg, r, 1'b0);
        rd(c_pg, 8'hff);
        cmd(1'b1, c_pg, 8'h00, 1'b1);
        cmd(1'b0, pmoe_pkg::CMD_CLEAR, 8'h00, 1'b0);
        cmd(1'b1, 8'h04 + 8'($urandom % 252), 8'($urandom), 1'b0);
        out(1'b0);
        $display("test page done");
        // no mode set: run field ignored; then bus mode alone
        cmd(1'b1, c_cfg, 8'h11, 1'b1);
        out(1'b1);
        cmd(1'b1, c_run, 8'h00, 1'b1);
        out(1'b1);
        cmd(1'b1, c_run, 8'h80, 1'b1);
        cmd(1'b1, c_cfg, 8'h19, 1'b1);
        rd(c_run, 8'h00);
        out(1'b0);
        r = 8'($urandom);
        cmd(1'b1, c_run, {2'b10, r[5:0]}, 1'b1);
        out(1'b1);
        cmd(1'b1, c_run, {2'b01, r[5:0]}, 1'b1);
        out(1'b1);
        cmd(1'b1, c_run, {2'b00, r[5:0]}, 1'b1);
        out(1'b0);
        cmd(1'b1, c_run, {2'b11, r[5:0]}, 1'b1);
        out(1'b0);
        $display("test bus mode done");
        // pin and bus modes together, bit 3 already set and output off at the write
        cmd(1'b1, c_cfg, 8'h1f, 1'b1);
        cmd(1'b1, c_run, 8'h80, 1'b1);
        out(1'b1);
        pmoe_host_i.pin(1'b0);
        out(1'b0);
        pmoe_host_i.pin(1'b1);
        out(1'b1);
        $display("test both modes done");
        // sticky faults and clear
        r = 8'($urandom) | 8'h01;
        fault_event <= r;
        @(posedge clock);
        fault_event <= 8'h00;
        @(negedge clock);
        chk(fault_status, r);
        @(posedge clock);
        cmd(1'b1, pmoe_pkg::CMD_CLEAR, 8'($urandom), 1'b1);
        @(negedge clock);
        chk(fault_status, 8'h00);
        @(posedge clock);
        // event held over the clearing cycle and the edge after it, status still set
        fault_event <= r;
        cmd(1'b1, pmoe_pkg::CMD_CLEAR, 8'h00, 1'b1);
        fault_event <= 8'h00;
        @(negedge clock);
        chk(fault_status, r);
        @(posedge clock);
        $display("test faults done");
        repeat (2) @(posedge clock);
        chk(8'(exp_q.size()), 8'h00);
        close_out();
    end
endmodule // tb_pmbus_output_enable_control
`default_nettype wire
